/* hdl/hdu_pkg.sv */
// Constants and types shared by the half-duplex serial port
package hdu_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_BUF = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_MODE_A = 8'h08;
  localparam logic [7:0] ADDR_MODE_B = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_LO = 8'h10;
  localparam logic [7:0] ADDR_BAUD_HI = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;

  // Values after reset
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_LO_RST = 8'hFF;
  localparam logic [3:0] BAUD_HI_RST = 4'hF;

  // Writable bits of the two mode registers
  localparam logic [7:0] MODE_A_MASK = 8'h37;
  localparam logic [7:0] MODE_B_MASK = 8'h7F;

  // Control register field
  localparam int CTL_RUN = 0;

  // serial_mode_a fields
  localparam int MA_DIR = 0;
  localparam int MA_CK_LO = 1;
  localparam int MA_CK_HI = 2;
  localparam int MA_RXSEL = 4;
  localparam int MA_RSS = 5;

  // serial_mode_b fields
  localparam int MB_LEN_LO = 0;
  localparam int MB_LEN_HI = 1;
  localparam int MB_PAR_LO = 2;
  localparam int MB_PAR_HI = 3;
  localparam int MB_STP = 4;
  localparam int MB_NEG = 5;
  localparam int MB_ORD = 6;

  // serial_status fields
  localparam int ST_FER = 0;
  localparam int ST_OER = 1;
  localparam int ST_PER = 2;
  localparam int ST_FUL = 3;

  // Baud generator: width of the count and longest period in ticks of the count source
  localparam int BAUD_W = 12;
  localparam int BAUD_MAX_PERIOD = 4096;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    HDU_IDLE,
    HDU_LOAD,
    HDU_START,
    HDU_DATA,
    HDU_PARITY,
    HDU_STOP
  } hdu_state_e;

endpackage

/* hdl/hdu_baud.sv */
// Baud generator: bit-period counter with bit edge and sample strobes
`timescale 1ns/100ps
module hdu_baud import hdu_pkg::*; #(
  parameter int CNT_W = BAUD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Selectable count sources, one-cycle enables in the clk domain
  input wire logic low_speed_clock,
  input wire logic high_speed_clock,
  input wire logic [1:0] clock_sel,
  // Programmed count and sample-point select
  input wire logic [CNT_W-1:0] count,
  input wire logic sample_point_select,
  // Restart the bit period from zero
  input wire logic restart,
  // Strobes
  output logic tick,
  output logic bit_edge,
  output logic sample
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } hdu_baud_s;

  hdu_baud_s s;
  hdu_baud_s next_s;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] spot;

  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("hdu_baud: CNT_W out of range");
  end

  always_comb begin
    // Code 00 low speed, 1x high speed, 01 not allowed and reads as low
    // count source select
    tick = clock_sel[1] ? high_speed_clock : low_speed_clock;
    half = count >> 1;
    // half count or half minus one
    spot = (sample_point_select && half != '0) ? half - 1'b1 : half;
    bit_edge = tick && !restart && (s.cnt == count);
    sample = tick && !restart && (s.cnt == spot);
    next_s = s;
    // period of count plus one ticks of the selected source
    if (restart) begin
      next_s.cnt = '0;
    end else if (tick) begin
      next_s.cnt = (s.cnt == count) ? '0 : s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* hdl/hdu_uart.sv */
// Half-duplex serial port with APB registers and baud generator
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps

module hdu_uart import hdu_pkg::*; #(
  parameter int CNT_W = BAUD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Baud count sources, one-cycle enables in the clk domain
  input wire logic low_speed_clock,
  input wire logic high_speed_clock,
  // Serial line and event
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_irq
);

  typedef struct packed {
    logic [7:0] tx_rx_buffer;
    logic run_bit;
    logic [7:0] serial_mode_a;
    logic [7:0] serial_mode_b;
    logic [7:0] baud_count_low;
    logic [3:0] baud_count_high;
    logic [3:0] serial_status;
    logic unread;
    hdu_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic par_bit;
    logic stop_cnt;
    logic copy_pend;
    logic [SYNC_STAGES-1:0] sync;
    logic rx_lvl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txd;
    logic irq;
  } hdu_uart_s;

  hdu_uart_s s;
  hdu_uart_s next_s;

  logic tick;
  logic bit_edge;
  logic sample;
  logic restart;
  logic direction_select;
  logic neg;
  logic msb_first;
  logic par_en;
  logic odd_par;
  logic two_stop;
  logic [3:0] len;
  logic line_bit;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] rd_byte;
  logic ful_set;
  logic ful_clr;
  logic oer_set;
  logic rx_done;
  logic rx_fer;
  logic rx_per;
  logic stat_clr;
  logic tx_bit;
  logic tx_drive;

  if (CNT_W != BAUD_W) begin : g_chk
    $error("hdu_uart: count width must match the baud registers");
  end

  function automatic logic [3:0] data_len(input logic [1:0] code);
    data_len = 4'h8 - {2'b00, code};
  endfunction

  function automatic logic [7:0] len_mask(input logic [3:0] n);
    len_mask = 8'hFF >> (4'h8 - n);
  endfunction

  // word reordered so the line always takes bit 0 first
  function automatic logic [7:0] tx_order(input logic [7:0] w,
                                          input logic [3:0] n,
                                          input logic msb);
    logic [7:0] m;
    logic [7:0] r;
    m = w & len_mask(n);
    for (int i = 0; i < 8; i++) begin
      r[i] = m[7-i];
    end
    tx_order = msb ? (r >> (4'h8 - n)) : m;
  endfunction

  // Parity bit for the given data and sense
  function automatic logic par_of(input logic [7:0] w, input logic odd);
    par_of = (^w) ^ odd;
  endfunction

  hdu_baud #(
    .CNT_W(CNT_W)
  ) u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .low_speed_clock(low_speed_clock),
    .high_speed_clock(high_speed_clock),
    .clock_sel({s.serial_mode_a[MA_CK_HI], s.serial_mode_a[MA_CK_LO]}),
    .count({s.baud_count_high, s.baud_count_low}),
    .sample_point_select(s.serial_mode_a[MA_RSS]),
    .restart(restart),
    .tick(tick),
    .bit_edge(bit_edge),
    .sample(sample)
  );

  always_comb begin
    direction_select = s.serial_mode_a[MA_DIR];
    neg = s.serial_mode_b[MB_NEG];
    msb_first = s.serial_mode_b[MB_ORD];
    par_en = !s.serial_mode_b[MB_PAR_HI];
    odd_par = s.serial_mode_b[MB_PAR_LO];
    two_stop = s.serial_mode_b[MB_STP];
    len = data_len({s.serial_mode_b[MB_LEN_HI], s.serial_mode_b[MB_LEN_LO]});
    // negative logic inverts the received level
    line_bit = s.rx_lvl ^ neg;
    acc = psel && penable && s.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    stat_clr = wr && paddr == ADDR_STAT;
    mapped = 1'b1;
    case (paddr)
      ADDR_BUF: rd_byte = s.tx_rx_buffer;
      ADDR_CTRL: rd_byte = {7'h00, s.run_bit};
      ADDR_MODE_A: rd_byte = s.serial_mode_a;
      ADDR_MODE_B: rd_byte = s.serial_mode_b;
      ADDR_BAUD_LO: rd_byte = s.baud_count_low;
      ADDR_BAUD_HI: rd_byte = {4'h0, s.baud_count_high};
      ADDR_STAT: rd_byte = {4'h0, s.serial_status};
      default: begin
        rd_byte = 8'h00;
        mapped = 1'b0;
      end
    endcase

    next_s = s;
    next_s.irq = 1'b0;
    restart = 1'b0;
    ful_set = 1'b0;
    ful_clr = 1'b0;
    oer_set = 1'b0;
    rx_done = 1'b0;
    rx_fer = 1'b0;
    rx_per = 1'b0;
    tx_bit = 1'b1;
    tx_drive = 1'b0;

    next_s.sync = {s.sync[SYNC_STAGES-2:0], serial_in_pin};
    if (s.sync[2] == s.sync[1]) begin
      next_s.rx_lvl = s.sync[2];
    end

    // APB: answer in the access phase after each setup cycle
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata = {24'h000000, rd_byte};
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end

    if (wr) begin
      case (paddr)
        ADDR_BUF: begin
          // full set on a transmit-mode write
          if (!direction_select) begin
            next_s.tx_rx_buffer = pwdata[7:0];
            ful_set = 1'b1;
          end
        end
        ADDR_MODE_A: next_s.serial_mode_a = pwdata[7:0] & MODE_A_MASK;
        ADDR_MODE_B: next_s.serial_mode_b = pwdata[7:0] & MODE_B_MASK;
        ADDR_BAUD_LO: next_s.baud_count_low = pwdata[7:0];
        ADDR_BAUD_HI: next_s.baud_count_high = pwdata[3:0];
        default: ;
      endcase
    end
    if (rd && paddr == ADDR_BUF) begin
      next_s.unread = 1'b0;
    end

    if (!s.run_bit) begin
      next_s.state = HDU_IDLE;
    end else if (!direction_select) begin
      // Transmitter, stepped on falling edges of the transfer clock
      if (bit_edge) begin
        case (s.state)
          HDU_LOAD: tx_drive = 1'b1;
          HDU_START: begin
            tx_bit = s.shreg[0];
            next_s.shreg = s.shreg >> 1;
            next_s.bit_cnt = 4'h1;
            next_s.state = HDU_DATA;
          end
          HDU_DATA: begin
            if (s.bit_cnt == len) begin
              if (par_en) begin
                tx_bit = s.par_bit;
                next_s.state = HDU_PARITY;
              end else begin
                next_s.stop_cnt = 1'b0;
                next_s.state = HDU_STOP;
              end
            end else begin
              tx_bit = s.shreg[0];
              next_s.shreg = s.shreg >> 1;
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
          end
          HDU_PARITY: begin
            next_s.stop_cnt = 1'b0;
            next_s.state = HDU_STOP;
          end
          HDU_STOP: begin
            if (two_stop && !s.stop_cnt) begin
              next_s.stop_cnt = 1'b1;
            end else if (s.serial_status[ST_FUL]) begin
              // interrupt after stop, next word follows at once
              tx_drive = 1'b1;
            end else begin
              next_s.run_bit = 1'b0;
              next_s.state = HDU_IDLE;
              next_s.irq = 1'b1;
            end
          end
          default: next_s.state = HDU_IDLE;
        endcase
      end
      if (tx_drive) begin
        // start bit, interrupt and full clear in one cycle
        next_s.shreg = tx_order(s.tx_rx_buffer, len, msb_first);
        next_s.par_bit = par_of(s.tx_rx_buffer & len_mask(len), odd_par);
        next_s.state = HDU_START;
        next_s.irq = 1'b1;
        ful_clr = 1'b1;
        tx_bit = 1'b0;
      end
    end else begin
      // receiver runs frame after frame while run is set
      case (s.state)
        HDU_IDLE: begin
          // start bit looked for on baud clock ticks
          // detection point is the timing reference
          if (tick && !line_bit) begin
            restart = 1'b1;
            next_s.state = HDU_START;
          end
        end
        HDU_START: begin
          if (sample) begin
            next_s.bit_cnt = 4'h0;
            next_s.shreg = 8'h00;
            next_s.state = line_bit ? HDU_IDLE : HDU_DATA;
          end
        end
        HDU_DATA: begin
          if (sample) begin
            if (msb_first) begin
              next_s.shreg[3'(len - 4'h1 - s.bit_cnt)] = line_bit;
            end else begin
              next_s.shreg[3'(s.bit_cnt)] = line_bit;
            end
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == len - 4'h1) begin
              next_s.copy_pend = !par_en;
              next_s.state = par_en ? HDU_PARITY : HDU_STOP;
            end
          end
        end
        HDU_PARITY: begin
          if (sample) begin
            next_s.par_bit = line_bit;
            next_s.copy_pend = 1'b1;
            next_s.state = HDU_STOP;
          end
        end
        HDU_STOP: begin
          // word copied on the following falling edge
          if (bit_edge && s.copy_pend) begin
            next_s.tx_rx_buffer = s.shreg;
            next_s.copy_pend = 1'b0;
            next_s.unread = 1'b1;
            oer_set = s.unread;
          end else if (sample && !s.copy_pend) begin
            // check stop and parity, then interrupt
            rx_done = 1'b1;
            rx_fer = !line_bit;
            rx_per = par_en && (s.par_bit != par_of(s.shreg, odd_par));
            next_s.irq = 1'b1;
            next_s.state = HDU_IDLE;
          end
        end
        default: next_s.state = HDU_IDLE;
      endcase
    end

    if (wr && paddr == ADDR_CTRL) begin
      if (!pwdata[CTL_RUN]) begin
        next_s.run_bit = 1'b0;
        next_s.state = HDU_IDLE;
        next_s.copy_pend = 1'b0;
      end else if (!s.run_bit) begin
        if (direction_select) begin
          next_s.run_bit = 1'b1;
          next_s.state = HDU_IDLE;
          // restart with the last word still unread
          oer_set = oer_set | s.unread;
        end else if (s.serial_status[ST_FUL]) begin
          // buffered word: start the transfer clock
          next_s.run_bit = 1'b1;
          next_s.state = HDU_LOAD;
          restart = 1'b1;
        end else begin
          next_s.irq = 1'b1;
        end
      end
    end

    // status write clears, a same-cycle event still sets
    if (stat_clr) begin
      next_s.serial_status = 4'h0;
    end
    // full set wins over its clear
    if (ful_clr) begin
      next_s.serial_status[ST_FUL] = 1'b0;
    end
    if (ful_set) begin
      next_s.serial_status[ST_FUL] = 1'b1;
    end
    if (oer_set) begin
      next_s.serial_status[ST_OER] = 1'b1;
    end
    // parity flag follows each completed reception
    if (rx_done) begin
      next_s.serial_status[ST_PER] = rx_per;
      next_s.serial_status[ST_FER] = rx_fer;
    end
    if (!direction_select) begin
      next_s.serial_status[ST_PER] = 1'b0;
      next_s.serial_status[ST_OER] = 1'b0;
      next_s.serial_status[ST_FER] = 1'b0;
    end else begin
      next_s.serial_status[ST_FUL] = 1'b0;
    end

    if (direction_select) begin
      next_s.txd = 1'b1;
    end else if (s.run_bit && (bit_edge || tx_drive)) begin
      // negative logic inverts the sent level
      next_s.txd = tx_bit ^ neg;
    end else if (!s.run_bit || s.state == HDU_IDLE) begin
      next_s.txd = !neg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.tx_rx_buffer <= BUF_RST;
      s.serial_mode_a <= MODE_RST;
      s.serial_mode_b <= MODE_RST;
      s.baud_count_low <= BAUD_LO_RST;
      s.baud_count_high <= BAUD_HI_RST;
      s.state <= HDU_IDLE;
      s.sync <= '1;
      s.rx_lvl <= 1'b1;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign serial_out_pin = s.txd;
  assign serial_irq = s.irq;

endmodule

/* bench/hdu_uart_checker.sv */
// Assertion checker for the half-duplex serial port
`timescale 1ns/100ps
module hdu_uart_checker import hdu_pkg::*; #(
  parameter int CNT_W = BAUD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial
  input wire logic low_speed_clock,
  input wire logic high_speed_clock,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic rx_mode;
  logic setup;
  logic mapped;
  assign setup = psel && !penable;
  assign mapped = paddr <= ADDR_STAT && paddr[1:0] == 2'b00;
  // Direction as last written by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_mode <= 1'b0;
    end else if (psel && penable && pready && pwrite &&
                 paddr == ADDR_MODE_A) begin
      rx_mode <= pwdata[MA_DIR];
    end
  end
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready in access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(setup))
    else $error("ready outside access cycle");
  upper_data_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  bad_addr_error_a: assert property (setup && !mapped |=> pslverr && pready)
    else $error("unmapped address not refused");
  good_addr_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped address refused");
  refused_read_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  irq_single_pulse_a: assert property (serial_irq |=> !serial_irq)
    else $error("interrupt longer than one cycle");
  rx_line_high_a: assert property (
    rx_mode && $past(rx_mode) |-> serial_out_pin)
    else $error("output not high in receive mode");
  cover property (serial_irq && !rx_mode);
  cover property (serial_irq && rx_mode);
  cover property (pready && pslverr);
endmodule

bind hdu_uart hdu_uart_checker #(.CNT_W(CNT_W)) hdu_uart_checker_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .low_speed_clock(low_speed_clock),
  .high_speed_clock(high_speed_clock), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_irq(serial_irq)
);

/* bench/hdu_line_model.sv */
// Remote serial device: sends frames to the port and decodes its frames
`timescale 1ns/100ps
module hdu_line_model (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // start, data in chosen order, parity, stop; bad stop is short
  task automatic send(input int pc, input logic [7:0] d, input int len,
      input logic [1:0] par, input logic msb, input logic bp, input logic bs);
    logic q[$];
    int k;
    q.push_back(1'b0);
    for (k = 0; k < len; k++) q.push_back(msb ? d[len-1-k] : d[k]);
    if (!par[1]) q.push_back(bp ^ par[0] ^ (^(d & 8'((1 << len) - 1))));
    q.push_back(!bs);
    @(posedge clk);
    foreach (q[k]) begin
      line_out <= q[k];
      repeat ((bs && k == q.size() - 1) ? pc / 2 + 2 : pc) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (2 * pc) @(posedge clk);
  endtask
  // decode a frame sampled at bit centres
  task automatic recv(input int pc, input int len, input logic [1:0] par,
      input logic neg, input logic msb, input int stops,
      output logic [7:0] d, output logic p, output logic ok);
    int k;
    d = 8'h00;
    p = 1'b0;
    for (k = 0; k < 64 * pc && (line_in ^ neg) === 1'b1; k++) @(posedge clk);
    repeat (pc / 2) @(posedge clk);
    ok = (line_in ^ neg) === 1'b0;
    for (k = 0; k < len; k++) begin
      repeat (pc) @(posedge clk);
      if (msb) d[len-1-k] = line_in ^ neg;
      else d[k] = line_in ^ neg;
    end
    if (!par[1]) begin
      repeat (pc) @(posedge clk);
      p = line_in ^ neg;
    end
    for (k = 0; k < stops; k++) begin
      repeat (pc) @(posedge clk);
      if ((line_in ^ neg) !== 1'b1) ok = 1'b0;
    end
  endtask
endmodule

/* bench/hdu_uart_tb.sv */
// Self-checking testbench for the half-duplex serial port
`timescale 1ns/100ps
module hdu_uart_tb import hdu_pkg::*;;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, d;
  logic [31:0] pwdata, prdata, rv;
  logic low_speed_clock = 1'b0;
  logic high_speed_clock, serial_in_pin, serial_out_pin;
  logic serial_irq, e, p, ok;
  int n_errors, comparisons, n_irq, i;
  // Bit period in clocks at count 7: low source pulses every other clock
  localparam int PL = 16;
  localparam int PH = 8;
  localparam logic [7:0] RV [7] = '{BUF_RST, 8'h00, MODE_RST, MODE_RST,
    BAUD_LO_RST, {4'h0, BAUD_HI_RST}, 8'h00};
  localparam logic [7:0] TXM [5] = '{8'h00, 8'h05, 8'h12, 8'h4B, 8'h20};
  localparam logic [7:0] TXA [5] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
  localparam logic [7:0] TXD [5] = '{8'hA5, 8'h5A, 8'h2B, 8'h13, 8'hC3};
  hdu_uart hdu_uart_i (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clock(low_speed_clock), .high_speed_clock(high_speed_clock),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_irq(serial_irq));
  hdu_line_model hdu_line_model_i (.clk(clk), .line_in(serial_out_pin),
    .line_out(serial_in_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    low_speed_clock <= ~low_speed_clock;
    if (serial_irq === 1'b1) n_irq <= n_irq + 1;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung transfer
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rv[7:0], exp);
  endtask
  task automatic wait_irq;
    int k, c;
    c = n_irq;
    for (k = 0; k < 4000 && n_irq == c; k++) @(posedge clk);
    chk({7'h0, n_irq != c}, 8'h01);
  endtask
  task automatic tx_one(input logic [7:0] mb, input logic [7:0] ma,
      input logic [7:0] dd);
    int pc, len, c;
    logic [7:0] dm;
    pc = ma[MA_CK_HI] ? PH : PL;
    len = 8 - int'(mb[1:0]);
    dm = dd & 8'((1 << len) - 1);
    wr(ADDR_MODE_A, ma);
    wr(ADDR_MODE_B, mb);
    wr(ADDR_BUF, dd);
    rd(ADDR_STAT, 8'h08);
    c = n_irq;
    wr(ADDR_CTRL, 8'h01);
    hdu_line_model_i.recv(pc, len, mb[3:2], mb[5], mb[6], 1 + int'(mb[4]),
      d, p, ok);
    chk(d, dm);
    chk({7'h0, p}, {7'h0, !mb[3] && (mb[2] ^ (^dm))});
    chk({7'h0, ok}, 8'h01);
    repeat (2 * pc) @(posedge clk);
    chk(8'(n_irq - c), 8'h02);
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, 8'h00);
    chk({7'h0, serial_out_pin}, {7'h0, !mb[5]});
  endtask
  task automatic rx_one(input logic [7:0] dd, input logic bp, input logic bs,
      input logic [7:0] st, input logic rdb);
    fork
      hdu_line_model_i.send(PL, dd, 8, 2'b00, 1'b0, bp, bs);
      wait_irq;
    join
    rd(ADDR_STAT, st);
    if (rdb) rd(ADDR_BUF, dd);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    n_errors++;
    end_of_test;
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    high_speed_clock = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i++) rd(8'(i * 4), RV[i]);
    apb(1'b0, 8'h1C, 8'h00);
    chk({7'h0, e}, 8'h01);
    wr(ADDR_MODE_A, 8'hFF);
    rd(ADDR_MODE_A, MODE_A_MASK);
    wr(ADDR_MODE_B, 8'hFF);
    rd(ADDR_MODE_B, MODE_B_MASK);
    wr(ADDR_MODE_A, 8'h00);
    wr(ADDR_MODE_B, 8'h00);
    wr(ADDR_BAUD_LO, 8'h07);
    wr(ADDR_BAUD_HI, 8'h00);
    $display("Test registers done");
    wr(ADDR_CTRL, 8'h01);
    wait_irq;
    rd(ADDR_CTRL, 8'h00);
    chk({7'h0, serial_out_pin}, 8'h01);
    for (i = 0; i < 5; i++) tx_one(TXM[i], TXA[i], TXD[i]);
    wr(ADDR_MODE_B, 8'h00);
    wr(ADDR_BUF, 8'h81);
    wr(ADDR_CTRL, 8'h01);
    fork
      begin
        hdu_line_model_i.recv(PL, 8, 2'b00, 1'b0, 1'b0, 1, d, p, ok);
        chk(d, 8'h81);
        hdu_line_model_i.recv(PL, 8, 2'b00, 1'b0, 1'b0, 1, d, p, ok);
        chk(d, 8'h7E);
      end
      begin
        wait_irq;
        wr(ADDR_BUF, 8'h7E);
      end
    join
    repeat (2 * PL) @(posedge clk);
    rd(ADDR_CTRL, 8'h00);
    $display("Test transmit done");
    wr(ADDR_MODE_A, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    chk({7'h0, serial_out_pin}, 8'h01);
    rx_one(8'hA5, 1'b0, 1'b0, 8'h00, 1'b1);
    rx_one(8'h3C, 1'b1, 1'b0, 8'h04, 1'b1);
    rx_one(8'h5A, 1'b0, 1'b1, 8'h01, 1'b1);
    rx_one(8'h11, 1'b0, 1'b0, 8'h00, 1'b0);
    rx_one(8'h22, 1'b0, 1'b0, 8'h02, 1'b1);
    wr(ADDR_STAT, 8'h00);
    rd(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE_A, 8'h21);
    wr(ADDR_CTRL, 8'h01);
    rx_one(8'hC3, 1'b0, 1'b0, 8'h00, 1'b0);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_STAT, 8'h02);
    rd(ADDR_BUF, 8'hC3);
    $display("Test receive done");
    end_of_test;
  end
endmodule
